// ### verilog/sim_card_uart_receiver.sv
// Smart-card receive channel: clock derivation, bit sampling, buffer and flags.
// Assumes pins synchronous to clk_sys; timer pulses are one clk_sys cycle wide.
`timescale 1ns/1ps
module sim_card_uart_receiver
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic serial_in_pin,
	input wire logic serial_in_dir,
	input wire logic transfer_clock_pin,
	input wire logic transfer_clock_dir,
	input wire logic clock_src_external,
	input wire logic inverse_format,
	input wire logic parity_enable,
	input wire logic parity_odd,
	input wire logic error_out_enable,
	input wire logic open_drain_sel,
	input wire logic [7:0] bitrate_reload,
	input wire logic bitrate_from_timer,
	input wire logic bitrate_source_timer_pulse,
	input wire logic [15:0] card_clock_timer,
	input wire logic rx_buf_low_read,
	input wire logic rx_irq_ack,
	output logic [7:0] rx_buf,
	output logic rx_complete,
	output logic rx_irq_req,
	output logic parity_error,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	output logic card_clock
);
	// Input gating, clock selection and divider taps
	logic armed;
	logic rx_line;
	logic ext_clk_line;
	logic ext_clk_prev_r;
	logic ext_clk_rise;
	logic brg_count_en;
	logic brg_tick;
	logic sample_tick;
	logic card_tick;
	logic card_clock_r;

	// Frame sequencing
	sim_rx_pkg::rx_state_e state_r;
	sim_rx_pkg::rx_state_e state_nxt;
	logic rx_line_prev_r;
	logic start_edge;
	logic [3:0] tick_cnt_r;
	logic [3:0] tick_cnt_nxt;
	logic mid_point;
	logic [2:0] bit_idx_r;
	logic [2:0] bit_idx_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic parity_acc_r;
	logic parity_acc_nxt;
	logic data_bit;
	logic last_bit;
	logic in_idle;
	logic in_parity;
	logic in_stop;
	logic parity_fail;
	logic buf_load;

	// Buffer, flags and error drive
	logic [7:0] rx_buf_r;
	logic rx_complete_r;
	logic rx_irq_req_r;
	logic parity_error_r;
	logic err_drive_r;

	// Inverse format flips the level of data and parity bits; order stays LSB first
	function automatic logic line_level(
		input logic raw,
		input logic inverse
	);
		return raw ^ inverse;
	endfunction

	function automatic logic state_is(
		input sim_rx_pkg::rx_state_e cur,
		input sim_rx_pkg::rx_state_e want
	);
		return cur == want;
	endfunction

	assign armed = tx_enable && rx_enable;
	// A pin turned to output reads as an idle line
	assign rx_line = serial_in_dir ? sim_rx_pkg::LINE_IDLE_RESET : serial_in_pin;
	assign ext_clk_line = transfer_clock_dir ? 1'b0 : transfer_clock_pin;
	assign ext_clk_rise = ext_clk_line && !ext_clk_prev_r;
	assign brg_count_en = bitrate_from_timer ? bitrate_source_timer_pulse : 1'b1;
	assign sample_tick = clock_src_external ? ext_clk_rise : brg_tick;

	// Tick rate is the main clock, or the timer pulse rate when bitrate_from_timer is set, over reload plus one; sixteen ticks make a bit
	sim_rate_div #(
		.WIDTH(8)
	) i_bitrate_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.count_en(brg_count_en),
		.reload(bitrate_reload),
		.tick(brg_tick)
	);

	sim_rate_div #(
		.WIDTH(16)
	) i_card_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.count_en(1'b1),
		.reload(card_clock_timer),
		.tick(card_tick)
	);

	assign in_idle = state_is(state_r, sim_rx_pkg::ST_IDLE);
	assign in_parity = state_is(state_r, sim_rx_pkg::ST_PARITY);
	assign in_stop = state_is(state_r, sim_rx_pkg::ST_STOP);
	assign start_edge = armed && in_idle && rx_line_prev_r && !rx_line;
	assign mid_point = sample_tick && (tick_cnt_r == sim_rx_pkg::MID_TICK);
	assign data_bit = line_level(rx_line, inverse_format);
	assign last_bit = (bit_idx_r == sim_rx_pkg::LAST_DATA_BIT);
	assign parity_fail = in_parity && mid_point && ((parity_acc_r ^ data_bit) != parity_odd);
	assign buf_load = in_stop && mid_point && armed;

	assign rx_buf = rx_buf_r;
	assign rx_complete = rx_complete_r;
	assign rx_irq_req = rx_irq_req_r;
	assign parity_error = parity_error_r;
	assign card_clock = card_clock_r;
	// Open drain only ever pulls low; push-pull idles high
	assign serial_out_pin_oe = open_drain_sel ? err_drive_r : 1'b1;
	assign serial_out_pin_o = open_drain_sel ? 1'b0 : !err_drive_r;

	// Tick count restarts at the start edge so samples land mid-bit
	always_comb
	begin
		tick_cnt_nxt = tick_cnt_r;
		if (start_edge)
			tick_cnt_nxt = sim_rx_pkg::TICK_RESET;
		else if (!in_idle && sample_tick)
			tick_cnt_nxt = tick_cnt_r + 4'h1;
	end

	always_comb
	begin
		state_nxt = state_r;
		bit_idx_nxt = bit_idx_r;
		shift_nxt = shift_r;
		parity_acc_nxt = parity_acc_r;
		unique case (state_r)
			sim_rx_pkg::ST_IDLE:
			begin
				if (start_edge)
				begin
					state_nxt = sim_rx_pkg::ST_START;
					bit_idx_nxt = 3'h0;
					parity_acc_nxt = 1'b0;
				end
			end
			sim_rx_pkg::ST_START:
			begin
				// A start bit gone high by mid-period was a glitch
				if (mid_point)
					state_nxt = rx_line ? sim_rx_pkg::ST_IDLE : sim_rx_pkg::ST_DATA;
			end
			sim_rx_pkg::ST_DATA:
			begin
				if (mid_point)
				begin
					shift_nxt = {data_bit, shift_r[7:1]};
					parity_acc_nxt = parity_acc_r ^ data_bit;
					bit_idx_nxt = bit_idx_r + 3'h1;
					if (last_bit)
						state_nxt = parity_enable ? sim_rx_pkg::ST_PARITY : sim_rx_pkg::ST_STOP;
				end
			end
			sim_rx_pkg::ST_PARITY:
			begin
				if (mid_point)
					state_nxt = sim_rx_pkg::ST_STOP;
			end
			sim_rx_pkg::ST_STOP:
			begin
				if (mid_point)
					state_nxt = sim_rx_pkg::ST_IDLE;
			end
			default:
				state_nxt = sim_rx_pkg::ST_IDLE;
		endcase
		if (!armed)
			state_nxt = sim_rx_pkg::ST_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= sim_rx_pkg::ST_IDLE;
			tick_cnt_r <= sim_rx_pkg::TICK_RESET;
			bit_idx_r <= 3'h0;
			shift_r <= 8'h00;
			parity_acc_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			bit_idx_r <= bit_idx_nxt;
			shift_r <= shift_nxt;
			parity_acc_r <= parity_acc_nxt;
		end
	end

	// Edge detectors reset to the idle levels so reset release shows no edge
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_line_prev_r <= sim_rx_pkg::LINE_IDLE_RESET;
			ext_clk_prev_r <= sim_rx_pkg::LINE_IDLE_RESET;
		end
		else
		begin
			rx_line_prev_r <= rx_line;
			ext_clk_prev_r <= ext_clk_line;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			card_clock_r <= sim_rx_pkg::CARD_CLOCK_RESET;
		else if (card_tick)
			card_clock_r <= !card_clock_r;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rx_buf_r <= sim_rx_pkg::RX_BUF_RESET;
		else if (buf_load)
			rx_buf_r <= shift_r;
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rx_complete_r <= 1'b0;
		else if (buf_load)
			rx_complete_r <= 1'b1;
		else if (rx_buf_low_read)
			rx_complete_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rx_irq_req_r <= 1'b0;
		else if (buf_load)
			rx_irq_req_r <= 1'b1;
		else if (rx_irq_ack)
			rx_irq_req_r <= 1'b0;
	end

	// Error flag holds until the next start bit
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			parity_error_r <= 1'b0;
		else if (parity_fail)
			parity_error_r <= 1'b1;
		else if (start_edge)
			parity_error_r <= 1'b0;
	end

	// Low level lasts from the parity sample to the stop sample, one bit long
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			err_drive_r <= 1'b0;
		else if (parity_fail && error_out_enable)
			err_drive_r <= 1'b1;
		else if (buf_load || !armed)
			err_drive_r <= 1'b0;
	end
endmodule

// ### include/sim_rx_pkg.sv
// Constants shared by the smart-card receiver channel.
// Assumes a single 10 MHz system clock and plain control ports, no register bus.
package sim_rx_pkg;
	localparam int DATA_BITS = 8;
	localparam int TICKS_PER_BIT = 16;
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam logic [7:0] RX_BUF_RESET = 8'h00;
	localparam logic [15:0] CARD_DIV_RESET = 16'h0000;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	localparam logic [3:0] TICK_RESET = 4'h0;
	localparam logic LINE_IDLE_RESET = 1'b1;
	localparam logic CARD_CLOCK_RESET = 1'b0;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PARITY = 3'b011,
		ST_STOP = 3'b100
	} rx_state_e;
endpackage

// ### verilog/sim_rate_div.sv
// Reloadable down-counter divider producing a one-cycle tick.
// Assumes a count-enable pulse on the system clock.
`timescale 1ns/1ps
module sim_rate_div #(
	parameter int WIDTH = 8
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic count_en,
	input wire logic [WIDTH-1:0] reload,
	output logic tick
);
	logic [WIDTH-1:0] cnt_r;
	wire at_zero = (cnt_r == '0);
	// Divides by reload plus one
	assign tick = count_en && at_zero;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else if (count_en)
			cnt_r <= at_zero ? reload : cnt_r - 1'b1;
	end
endmodule

// ### dv/sim_card_model.sv
// Card side: sends one frame per go pulse, idle high, bit_cycles clocks per bit.
// Assumes go is only honoured once the previous frame has left the line.
`timescale 1ns/1ps
module sim_card_model
(
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [7:0] frame_byte,
	input wire logic with_parity,
	input wire logic bad_parity,
	input wire logic inverse,
	input wire logic [7:0] bit_cycles,
	output logic line
);
	logic [10:0] frame_r = 11'h7FF;
	logic [3:0] bits_left_r = 4'h0;
	logic [7:0] cyc_r = 8'h00;
	logic [7:0] data;
	logic parity;
	// Even parity over the logical data; inverse flips levels only
	assign data = inverse ? ~frame_byte : frame_byte;
	assign parity = (^frame_byte) ^ bad_parity;
	always @(posedge clk_sys)
	begin
		if (go && bits_left_r == 4'h0)
		begin
			frame_r <= with_parity ? {1'b1, inverse ^ parity, data, 1'b0} : {2'b11, data, 1'b0};
			bits_left_r <= with_parity ? 4'hB : 4'hA;
			cyc_r <= bit_cycles - 8'h01;
		end
		else if (bits_left_r != 4'h0)
		begin
			if (cyc_r == 8'h00)
			begin
				frame_r <= {1'b1, frame_r[10:1]};
				bits_left_r <= bits_left_r - 4'h1;
				cyc_r <= bit_cycles - 8'h01;
			end
			else
				cyc_r <= cyc_r - 8'h01;
		end
	end
	// Start bit, data least significant first, optional parity, stop
	assign line = (bits_left_r != 4'h0) ? frame_r[0] : 1'b1;
endmodule

// ### dv/sim_rx_checker.sv
// Receive flag and error output drive checks; sees the receiver's ports only.
`timescale 1ns/1ps
module sim_rx_checker
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic error_out_enable,
	input wire logic rx_complete,
	input wire logic rx_irq_req,
	input wire logic parity_error,
	input wire logic rx_buf_low_read,
	input wire logic open_drain_sel,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic [7:0] rx_buf
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	flag_irq_a: assert property ($rose(rx_complete) |-> rx_irq_req) else $error("irq not raised");
	irq_pair_a: assert property ($rose(rx_irq_req) |-> rx_complete) else $error("flag not set");
	buf_load_a: assert property ($changed(rx_buf) |-> rx_complete) else $error("buf moved");
	read_clear_a: assert property (rx_buf_low_read
		|=> !rx_complete || $changed(rx_buf)) else $error("flag kept after read");
	drain_a: assert property (open_drain_sel && serial_out_pin_oe
		|-> !serial_out_pin_o) else $error("open drain drove high");
	cmos_drive_a: assert property (!open_drain_sel |-> serial_out_pin_oe) else $error("push-pull off");
	arm_gate_a: assert property (!(tx_enable && rx_enable)
		|=> !$rose(rx_complete)) else $error("load while disarmed");
	err_low_a: assert property ($rose(parity_error) && $past(error_out_enable)
		|-> serial_out_pin_oe && !serial_out_pin_o) else $error("no error level");
endmodule
bind sim_card_uart_receiver sim_rx_checker u_chk(.*);

// ### dv/tb_sim_card_uart_receiver.sv
// Bench: card frames in each clock source and format, flag clears, reset, card clock.
// Assumes the card model drives the line and the bench plays the reading processor.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_sim_card_uart_receiver;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic rd = 1'b0;
	logic ack = 1'b0;
	logic tog = 1'b0;
	logic tx_en = 1'b1;
	logic rx_en = 1'b1;
	logic clk_ext = 1'b0;
	logic inv = 1'b0;
	logic par_en = 1'b0;
	logic err_en = 1'b1;
	logic od_sel = 1'b1;
	logic from_timer = 1'b0;
	logic m_bad = 1'b0;
	logic cc;
	logic [7:0] brg_reload = 8'h00;
	logic [7:0] m_byte = 8'h00;
	logic [7:0] m_cycles = 8'h10;
	logic [15:0] card_div = 16'h0000;
	logic rx_in;
	logic rx_complete;
	logic rx_irq_req;
	logic parity_error;
	logic so_o;
	logic so_oe;
	logic card_clock;
	logic [7:0] rx_buf;
	int miscompares = 0;
	int num_checks = 0;
	sim_card_model i_card(.clk_sys, .go, .frame_byte(m_byte), .with_parity(par_en),
		.bad_parity(m_bad), .inverse(inv), .bit_cycles(m_cycles), .line(rx_in));
	sim_card_uart_receiver i_dut(.clk_sys, .rst_n, .tx_enable(tx_en), .rx_enable(rx_en),
		.serial_in_pin(rx_in), .serial_in_dir('0), .transfer_clock_pin(tog), .transfer_clock_dir('0),
		.clock_src_external(clk_ext), .inverse_format(inv), .parity_enable(par_en),
		.parity_odd(1'b0), .error_out_enable(err_en), .open_drain_sel(od_sel),
		.bitrate_reload(brg_reload), .bitrate_from_timer(from_timer),
		.bitrate_source_timer_pulse(tog), .card_clock_timer(card_div), .rx_buf_low_read(rd),
		.rx_irq_ack(ack), .rx_buf, .rx_complete, .rx_irq_req, .parity_error,
		.serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .card_clock);
	task automatic send_frame(input logic [7:0] value, input logic bad, input logic [7:0] cycles);
		repeat (40) @(posedge clk_sys);
		m_byte <= value;
		m_bad <= bad;
		m_cycles <= cycles;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
	endtask
	task automatic wait_complete;
		repeat (600) if (rx_complete !== 1'b1) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic read_and_ack;
		@(posedge clk_sys);
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(rx_complete, 1'b0)
		`CHK(rx_irq_req, 1'b1)
		@(posedge clk_sys);
		ack <= 1'b1;
		@(posedge clk_sys);
		ack <= 1'b0;
		@(negedge clk_sys);
		`CHK(rx_irq_req, 1'b0)
	endtask
	always @(posedge clk_sys)
		tog <= ~tog;
	task complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial forever #50 clk_sys = ~clk_sys;
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		complete_run;
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Direct format, internal clock dividing by one
		send_frame(8'hA5, 1'b0, 8'h10);
		wait_complete;
		`CHK(rx_buf, 8'hA5)
		`CHK(rx_complete, 1'b1)
		`CHK(rx_irq_req, 1'b1)
		`CHK(parity_error, 1'b0)
		`CHK(so_oe, 1'b0)
		read_and_ack;
		// Inverse format on the external clock pin with good even parity
		@(posedge clk_sys);
		inv <= 1'b1;
		clk_ext <= 1'b1;
		par_en <= 1'b1;
		send_frame(8'h3C, 1'b0, 8'h20);
		wait_complete;
		`CHK(rx_buf, 8'h3C)
		`CHK(parity_error, 1'b0)
		read_and_ack;
		// Bad parity, internal clock reloaded with one, open drain error level
		@(posedge clk_sys);
		inv <= 1'b0;
		clk_ext <= 1'b0;
		brg_reload <= 8'h01;
		send_frame(8'h5A, 1'b1, 8'h20);
		repeat (600) if (so_oe !== 1'b1) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(so_oe, 1'b1)
		`CHK(so_o, 1'b0)
		wait_complete;
		`CHK(parity_error, 1'b1)
		`CHK(rx_buf, 8'h5A)
		read_and_ack;
		// Timer pulses as the generator source, push-pull output
		@(posedge clk_sys);
		par_en <= 1'b0;
		brg_reload <= 8'h00;
		from_timer <= 1'b1;
		od_sel <= 1'b0;
		send_frame(8'hC3, 1'b0, 8'h20);
		wait_complete;
		`CHK(rx_buf, 8'hC3)
		`CHK(parity_error, 1'b0)
		`CHK(so_oe, 1'b1)
		`CHK(so_o, 1'b1)
		read_and_ack;
		// Reset in mid-frame, then the rest of that frame while disarmed; the go for 8'h96 falls mid-frame and is ignored
		send_frame(8'h81, 1'b0, 8'h20);
		repeat (100) @(posedge clk_sys);
		rst_n <= 1'b0;
		tx_en <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		`CHK(rx_buf, 8'h00)
		`CHK(rx_complete, 1'b0)
		`CHK(rx_irq_req, 1'b0)
		`CHK(card_clock, 1'b0)
		send_frame(8'h96, 1'b0, 8'h20);
		repeat (450) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(rx_complete, 1'b0)
		`CHK(rx_buf, 8'h00)
		// Card clock: divide by three, then halve
		@(posedge clk_sys);
		tx_en <= 1'b1;
		card_div <= 16'h0002;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		cc = card_clock;
		repeat (3) @(negedge clk_sys);
		`CHK(card_clock, !cc)
		repeat (3) @(negedge clk_sys);
		`CHK(card_clock, cc)
		complete_run;
	end
endmodule
